// ### hdl/pmnc_pkg.sv
// Shared constants and types for the numeric push-motion command handler.
// Assumes a 10 MHz system clock and an on-chip byte receiver/transmitter.
package pmnc_pkg;
	// Frame fields
	localparam logic [7:0]  FUNC_WRITE_MULTI = 8'h10;  // Write multiple registers
	localparam logic [7:0]  BCAST_ADDR       = 8'h00;  // Broadcast, no reply
	localparam logic [7:0]  DEFAULT_SLAVE    = 8'h01;  // Axis 0 station address
	localparam logic [8:0]  HDR_LEN          = 9'h007; // Addr..byte count
	localparam logic [8:0]  CRC_LEN          = 9'h002; // Error check bytes
	localparam logic [8:0]  MAX_FRAME        = 9'h100; // Longest frame in bytes
	localparam logic [3:0]  REPLY_HDR_LEN    = 4'h6;   // Echoed header bytes
	localparam logic [3:0]  REPLY_LEN        = 4'h8;   // Echo plus error check
	// Register window
	localparam logic [15:0] REG_TARGET_POS   = 16'h9900;
	localparam logic [15:0] REG_PUSH_CURRENT = 16'h9907;
	localparam logic [15:0] REG_CONTROL_FLAG = 16'h9908;
	localparam int          NUM_REGS         = 9;
	localparam logic [16:0] REG_END          = 17'h09909; // One past last word
	// Word indices inside the window
	localparam int          IDX_POS_HI       = 0;
	localparam int          IDX_BAND_HI      = 2;
	localparam int          IDX_SPEED_HI     = 4;
	localparam int          IDX_ACCEL        = 6;
	localparam int          IDX_PUSH         = 7;
	localparam int          IDX_FLAG         = 8;
	// Control flag fields
	localparam int          FLAG_PUSH_BIT    = 1;
	localparam int          FLAG_ALT_BIT     = 2;
	localparam logic [15:0] FLAG_RESET       = 16'h0000; // Normal movement
	localparam logic [15:0] REG_RESET        = 16'h0000;
	// Error check
	localparam logic [15:0] CRC_INIT         = 16'hffff;
	localparam logic [15:0] CRC_POLY         = 16'ha001;
	localparam logic [15:0] CRC_GOOD         = 16'h0000; // Residue over whole frame
	// Timing
	localparam int          CLK_MHZ          = 10;
	localparam int          SILENCE_US       = 1750;   // Inter-frame silence
	localparam int          SILENCE_CYC      = SILENCE_US * CLK_MHZ;
	// Frame handler states
	typedef enum logic [2:0] {
		ST_IDLE, ST_RECV, ST_EVAL, ST_COMMIT, ST_REPLY
	} pmnc_state_t;
endpackage

// ### hdl/pmnc_crc_if.sv
// Byte feed and running check value between frame handler and CRC engine.
// Assumes both ends share one clock.
interface pmnc_crc_if;
	logic        clear; // Restart from initial value with this byte
	logic        valid; // Byte present this cycle
	logic [7:0]  data;  // Byte to fold in
	logic [15:0] crc;   // Running value
	modport user   (output clear, output valid, output data, input crc);
	modport engine (input clear, input valid, input data, output crc);
endinterface

// ### hdl/pmnc_crc16.sv
// Byte-serial error-check engine, reflected polynomial, LSB first.
// Assumes at most one byte per clock and a synchronous reset.
module pmnc_crc16 import pmnc_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Byte feed
	pmnc_crc_if.engine crc_port
);
	// One byte folded in, eight shift steps unrolled by the loop
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int b = 0; b < 8; b++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	wire [15:0] seed     = crc_port.clear ? CRC_INIT : crc_port.crc; // Start value
	wire [15:0] next_crc = crc_step(seed, crc_port.data);

	// Running value; holds when no byte arrives
	always_ff @(posedge clk) begin
		if (reset)
			crc_port.crc <= CRC_INIT;
		else if (crc_port.valid)
			crc_port.crc <= next_crc;
	end
endmodule

// ### hdl/pmnc_core.sv
// Frame handler for numeric motion commands over a serial slave link.
// Assumes byte receive/transmit logic on the same clock and a motion
// controller that reports busy and a one-cycle pulse when a move begins.
// Operation
// R1: full block with push flag starts push
// R2: push current and flag writable mid-push
// R3: mid-push update keeps move, new current
// R4: byte count equals twice register count
// R5: reply echoes header, then fresh check
// R6: 32-bit values sent upper word first
// R7: position and band in hundredths millimetre
// R8: speed, accel in hundredths; accel one word
// R9: push current on 0 to 255 scale
// R10: flag bit1 selects push, bit2 free
// R11: band never changes a move in progress
// R12: frame acted on only after check passes
// R13: flag returns to zero once movement begins
// R14: silence on the line delimits frames
module pmnc_core import pmnc_pkg::*; #(
	parameter logic [7:0] SLAVE_ADDR = DEFAULT_SLAVE,
	parameter int         GAP_CYCLES = SILENCE_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Received bytes
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	// Reply bytes
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// Motion controller
	input  wire logic        motion_busy,
	input  wire logic        move_started,
	output logic      [31:0] cmd_position,
	output logic      [31:0] cmd_band,
	output logic      [31:0] cmd_speed,
	output logic      [15:0] cmd_accel,
	output logic      [15:0] cmd_push_current,
	output logic      [15:0] cmd_flag,
	output logic             start_push,
	output logic             current_update,
	output logic             frame_error
);
	localparam int GW = $clog2(GAP_CYCLES + 1);

	// Refuse a silence too short to separate a frame from its evaluation
	if (GAP_CYCLES < 2) begin : g_bad_gap
		$error("GAP_CYCLES must be at least 2");
	end

	pmnc_state_t     state;                // Frame handler state
	logic [8:0]      rx_cnt;               // Bytes seen in this frame
	logic [GW-1:0]   gap_cnt;              // Idle cycles since last byte
	logic            overflow;             // Frame longer than allowed
	logic [7:0]      hdr_addr;             // Station address
	logic [7:0]      hdr_func;             // Function code
	logic [15:0]     hdr_start;            // First register
	logic [15:0]     hdr_count;            // Register count
	logic [7:0]      hdr_bytes;            // Byte count field
	logic [7:0]      data_hi;              // Upper byte awaiting its partner
	logic [15:0]     stage [NUM_REGS];     // Words held until the check passes
	logic [NUM_REGS-1:0] stage_mask;       // Words written by this frame
	logic [15:0]     regs [NUM_REGS];      // Register window
	logic [3:0]      tx_cnt;               // Reply bytes loaded

	pmnc_crc_if crc_bus ();

	pmnc_crc16 u_pmnc_crc16 (
		.clk      (clk),
		.reset    (reset),
		.crc_port (crc_bus.engine)
	);

	// Data field decode: upper byte first, one word per two bytes
	wire [8:0]  data_k    = rx_cnt - HDR_LEN;
	wire [15:0] widx      = hdr_start - REG_TARGET_POS + {8'h00, data_k[8:1]};
	wire        word_hit  = widx < 16'(NUM_REGS);
	wire        in_data   = rx_cnt >= HDR_LEN && rx_cnt < HDR_LEN + {1'b0, hdr_bytes};
	wire        rx_take   = (state == ST_IDLE || state == ST_RECV) && rx_valid;
	wire        gap_done  = gap_cnt == GW'(GAP_CYCLES - 1);
	// A byte arriving in the first idle cycle is byte zero, whatever count is left over
	wire [8:0]  rx_pos    = state == ST_IDLE ? 9'h000 : rx_cnt;

	// Frame acceptance
	wire        len_ok    = rx_cnt == HDR_LEN + {1'b0, hdr_bytes} + CRC_LEN;
	wire        range_ok  = hdr_start >= REG_TARGET_POS && hdr_count != 16'h0000
		&& {1'b0, hdr_start} + {1'b0, hdr_count} <= REG_END;
	wire        bytes_ok  = {8'h00, hdr_bytes} == {hdr_count[14:0], 1'b0}; // see R4
	wire        bcast     = hdr_addr == BCAST_ADDR;
	wire        addr_ok   = hdr_addr == SLAVE_ADDR || bcast;
	wire        crc_ok    = crc_bus.crc == CRC_GOOD;
	wire        frame_ok  = crc_ok && !overflow && len_ok && range_ok && bytes_ok
		&& addr_ok && hdr_func == FUNC_WRITE_MULTI; // see R12
	wire        full_blk  = &stage_mask;

	// Reply: header echo without byte count or data, then check low byte first
	wire        tx_load   = state == ST_REPLY && (!tx_valid || tx_ready) && tx_cnt != REPLY_LEN;
	wire [7:0]  reply_byte = tx_cnt == 4'h0 ? hdr_addr :
		tx_cnt == 4'h1 ? hdr_func :
		tx_cnt == 4'h2 ? hdr_start[15:8] :
		tx_cnt == 4'h3 ? hdr_start[7:0] :
		tx_cnt == 4'h4 ? hdr_count[15:8] :
		tx_cnt == 4'h5 ? hdr_count[7:0] :
		tx_cnt == 4'h6 ? crc_bus.crc[7:0] : crc_bus.crc[15:8]; // see R5

	// The one engine serves both directions; a reply never overlaps a receive
	assign crc_bus.clear = (state == ST_IDLE && rx_valid) || (tx_load && tx_cnt == 4'h0);
	assign crc_bus.valid = rx_take || (tx_load && tx_cnt < REPLY_HDR_LEN);
	assign crc_bus.data  = state == ST_REPLY ? reply_byte : rx_data;

	// Band is taken over only while idle, so a move keeps its band
	wire [15:0] band_hi   = stage_mask[IDX_BAND_HI] && state == ST_COMMIT
		? stage[IDX_BAND_HI] : regs[IDX_BAND_HI];
	wire [15:0] band_lo   = stage_mask[IDX_BAND_HI + 1] && state == ST_COMMIT
		? stage[IDX_BAND_HI + 1] : regs[IDX_BAND_HI + 1];
	wire        flag_we   = state == ST_COMMIT && stage_mask[IDX_FLAG];

	// Words in value order: upper word at the lower address
	assign cmd_position     = {regs[IDX_POS_HI], regs[IDX_POS_HI + 1]};     // see R6, R7
	assign cmd_speed        = {regs[IDX_SPEED_HI], regs[IDX_SPEED_HI + 1]}; // see R6, R8
	assign cmd_accel        = regs[IDX_ACCEL];                              // see R8
	assign cmd_push_current = regs[IDX_PUSH];                               // see R9
	assign cmd_flag         = regs[IDX_FLAG];                               // see R10

	// Frame sequencing: silence closes a frame, then check, apply, reply
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:   if (rx_valid) state <= ST_RECV;
				ST_RECV:   if (gap_done && !rx_valid) state <= ST_EVAL; // see R14
				ST_EVAL:   state <= frame_ok ? ST_COMMIT : ST_IDLE;    // see R12
				ST_COMMIT: state <= bcast ? ST_IDLE : ST_REPLY;
				ST_REPLY:  if (state == ST_REPLY && tx_cnt == REPLY_LEN && (!tx_valid || tx_ready))
					state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	// Byte and silence counters; bytes beyond the limit mark the frame bad
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_cnt   <= 9'h000;
			gap_cnt  <= '0;
			overflow <= 1'b0;
		end else if (state == ST_IDLE) begin
			rx_cnt   <= rx_valid ? 9'h001 : 9'h000;
			gap_cnt  <= '0;
			overflow <= 1'b0;
		end else if (rx_take) begin
			rx_cnt   <= rx_cnt == MAX_FRAME ? rx_cnt : rx_cnt + 9'h001;
			overflow <= overflow || rx_cnt == MAX_FRAME;
			gap_cnt  <= '0;
		end else if (state == ST_RECV) begin
			gap_cnt  <= gap_cnt + GW'(1); // see R14
		end
	end

	// Header capture by byte position
	always_ff @(posedge clk) begin
		if (reset) begin
			hdr_addr  <= 8'h00;
			hdr_func  <= 8'h00;
			hdr_start <= 16'h0000;
			hdr_count <= 16'h0000;
			hdr_bytes <= 8'h00;
			data_hi   <= 8'h00;
		end else if (rx_take) begin
			case (rx_pos)
				9'h000:  hdr_addr         <= rx_data;
				9'h001:  hdr_func         <= rx_data;
				9'h002:  hdr_start[15:8]  <= rx_data;
				9'h003:  hdr_start[7:0]   <= rx_data;
				9'h004:  hdr_count[15:8]  <= rx_data;
				9'h005:  hdr_count[7:0]   <= rx_data;
				9'h006:  hdr_bytes        <= rx_data;
				default: if (!data_k[0]) data_hi <= rx_data; // see R6
			endcase
		end
	end

	// Per-word staging and commit; any run inside the window is legal
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
		wire stage_we  = state == ST_RECV && rx_valid && in_data && data_k[0]
			&& word_hit && widx[3:0] == 4'(i); // see R2
		wire commit_we = state == ST_COMMIT && stage_mask[i];
		always_ff @(posedge clk) begin
			if (reset) begin
				stage[i]      <= REG_RESET;
				stage_mask[i] <= 1'b0;
			end else begin
				if (stage_we)
					stage[i] <= {data_hi, rx_data};
				if (state == ST_IDLE)
					stage_mask[i] <= 1'b0;
				else if (stage_we)
					stage_mask[i] <= 1'b1;
			end
		end
		// A host write in the same cycle outranks the move-start clear
		always_ff @(posedge clk) begin
			if (reset)
				regs[i] <= i == IDX_FLAG ? FLAG_RESET : REG_RESET;
			else if (commit_we)
				regs[i] <= stage[i];
			else if (i == IDX_FLAG && move_started)
				regs[i] <= FLAG_RESET; // see R13
		end
	end

	// Motion triggers and the band held for the move
	always_ff @(posedge clk) begin
		if (reset) begin
			start_push     <= 1'b0;
			current_update <= 1'b0;
			frame_error    <= 1'b0;
			cmd_band       <= 32'h0000_0000;
		end else begin
			start_push     <= state == ST_COMMIT && full_blk
				&& stage[IDX_FLAG][FLAG_PUSH_BIT]; // see R1, R10
			current_update <= state == ST_COMMIT && !full_blk
				&& stage_mask[IDX_PUSH] && motion_busy; // see R3
			frame_error    <= state == ST_EVAL && !frame_ok && hdr_addr == SLAVE_ADDR;
			if (!motion_busy)
				cmd_band <= {band_hi, band_lo}; // see R11, R7
		end
	end

	// Reply transmitter with valid/ready hold
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_cnt   <= 4'h0;
		end else if (state == ST_COMMIT) begin
			tx_cnt   <= 4'h0;
		end else if (tx_load) begin
			tx_valid <= 1'b1;
			tx_data  <= reply_byte; // see R5
			tx_cnt   <= tx_cnt + 4'h1;
		end else if (state == ST_REPLY && tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_ok_eval;
		state == ST_EVAL && frame_ok && !bcast;
	endsequence
	sequence s_first_reply;
		tx_valid && tx_data == hdr_addr ##0 tx_cnt == 4'h1;
	endsequence

	chk_reply_starts_echo: assert property (s_ok_eval |-> ##3 s_first_reply) // see R5
		else $error("reply did not start with station address");
	chk_bad_check_drop: assert property (state == ST_EVAL && !crc_ok |=> state == ST_IDLE) // see R12
		else $error("frame with bad check was acted on");
	chk_silence_ends_frame: assert property (state == ST_RECV && gap_done && !rx_valid // see R14
		|=> state == ST_EVAL)
		else $error("silence did not close frame");
	chk_push_needs_block: assert property (start_push |-> $past(state) == ST_COMMIT // see R1
		&& $past(full_blk) && cmd_flag[FLAG_PUSH_BIT])
		else $error("push started without full block");
	chk_update_no_restart: assert property (current_update |-> !start_push // see R3
		&& cmd_push_current == $past(stage[IDX_PUSH]))
		else $error("current update restarted move or lost value");
	chk_band_frozen_busy: assert property ($past(motion_busy) |-> $stable(cmd_band)) // see R11
		else $error("band changed during motion");
	chk_flag_clear_start: assert property (move_started && !flag_we // see R13
		|=> cmd_flag == FLAG_RESET)
		else $error("flag not cleared when move began");
	chk_bytecount_gate: assert property (state == ST_EVAL && !bytes_ok // see R4
		|=> state == ST_IDLE ##1 !start_push)
		else $error("frame with wrong byte count accepted");
	// Broadcast writes apply but never answer
	chk_bcast_no_reply: assert property (state == ST_COMMIT && bcast // see R5
		|=> state == ST_IDLE && !tx_valid)
		else $error("broadcast frame was answered");
endmodule

// ### testbench/pmnc_host_model.sv
// Host-side master model: sends write frames byte by byte, then
// collects the reply while stalling the sink every other cycle.
// Assumes the handler's byte strobes run on the same clock.
module pmnc_host_model #(
	parameter int GAP_CYCLES = 8
) (
	// Clock
	input  wire logic       clk,
	// Byte stream toward the handler
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	// Reply stream from the handler
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rsp[$]; // Reply bytes taken so far

	// Quiet line at time zero
	initial begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// Reflected 16-bit check, initial all ones, sent low byte first
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction

	// Silence, then bytes with a check; corrupt flips one check bit
	task automatic send(input logic [7:0] q[$], input logic corrupt);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0000, corrupt};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		repeat (GAP_CYCLES) @(posedge clk);
		foreach (q[i]) begin
			@(posedge clk);
			rx_data  <= q[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			rx_data  <= ~q[i]; // Released line shows no stale byte
			rx_valid <= 1'b0;
		end
	endtask

	// Take up to 8 reply bytes within lim cycles; slow sink on purpose
	task automatic collect(input int lim);
		rsp.delete();
		for (int i = 0; i < lim && rsp.size() < 8; i++) begin
			@(posedge clk);
			if (tx_valid && tx_ready)
				rsp.push_back(tx_data);
			tx_ready <= ~tx_ready & (rsp.size() < 8);
		end
	endtask
endmodule

// ### testbench/tb_push_motion_numeric_command.sv
// Self-checking bench for the numeric push-motion command handler.
// Assumes the host model drives bytes and the bench plays the motor.
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module tb_push_motion_numeric_command import pmnc_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int GAP = 8; // Short silence keeps the run brief
	logic        clk, reset, motion_busy, move_started;
	wire  [7:0]  rx_data, tx_data;
	wire         rx_valid, tx_valid, tx_ready, sp, cu, fe;
	wire  [31:0] pos, band, spd;
	wire  [15:0] acc, push, flag;
	int          num_errors = 0, n_compared = 0, n_sp = 0, n_cu = 0, n_fe = 0;
	logic [7:0]  q[$]; // Frame being built
	logic [7:0]  dst = 8'h01; // Station that the next frame addresses

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	pmnc_core #(.SLAVE_ADDR(8'h01), .GAP_CYCLES(GAP)) u_pmnc_core (
		.clk(clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.motion_busy(motion_busy), .move_started(move_started),
		.cmd_position(pos), .cmd_band(band), .cmd_speed(spd), .cmd_accel(acc),
		.cmd_push_current(push), .cmd_flag(flag), .start_push(sp),
		.current_update(cu), .frame_error(fe));

	pmnc_host_model #(.GAP_CYCLES(GAP)) u_pmnc_host_model (
		.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	// Count the one-cycle pulses
	always @(posedge clk) begin
		n_sp += (sp === 1'b1);
		n_cu += (cu === 1'b1);
		n_fe += (fe === 1'b1);
	end

	// Write frame; adj skews the byte count, bad spoils the check
	task automatic frame(input logic [15:0] st, input logic [15:0] w[$],
			input logic [7:0] adj, input logic bad);
		q = {dst, 8'h10, st[15:8], st[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size()) + adj};
		foreach (w[i]) begin
			q.push_back(w[i][15:8]); // Upper byte first
			q.push_back(w[i][7:0]);
		end
		u_pmnc_host_model.send(q, bad);
	endtask

	// Expect the echoed header and a fresh check
	task automatic reply(input logic [15:0] st, input logic [7:0] n);
		logic [15:0] c;
		q = {8'h01, 8'h10, st[15:8], st[7:0], 8'h00, n};
		c = u_pmnc_host_model.crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		u_pmnc_host_model.collect(GAP + 100);
		`CHK("reply_len", 8, u_pmnc_host_model.rsp.size())
		foreach (q[i]) `CHK("reply_byte", q[i], u_pmnc_host_model.rsp[i])
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end

	initial begin
		reset        = 1'b1;
		motion_busy  = 1'b0;
		move_started = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("reset_outs", 0, {pos, band, spd, acc, push, flag, tx_valid, sp})
		q = {8'h01, 8'h10, 8'h99, 8'h00, 8'h00, 8'h09};
		`CHK("crc_ref", 16'h932e, u_pmnc_host_model.crc16(q))
		// Full block with push flag starts a push
		frame(16'h9900, {16'h0000, 16'h1388, 16'h0000, 16'h07d0, 16'h0000, 16'h2710,
			16'h001e, 16'h00b2, 16'h0006}, 8'h00, 1'b0);
		reply(16'h9900, 8'h09);
		`CHK("position", 32'h00001388, pos)
		`CHK("band", 32'h000007d0, band)
		`CHK("speed", 32'h00002710, spd)
		`CHK("accel", 16'h001e, acc)
		`CHK("push", 16'h00b2, push)
		`CHK("flag", 16'h0006, flag)
		`CHK("start_push", 1, n_sp)
		// Movement begins: flag falls back to normal
		move_started <= 1'b1;
		motion_busy  <= 1'b1;
		@(posedge clk);
		move_started <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("flag_clear", 16'h0000, flag)
		// Mid-push force change keeps the move
		frame(16'h9907, {16'h007f, 16'h0006}, 8'h00, 1'b0);
		reply(16'h9907, 8'h02);
		`CHK("push_new", 16'h007f, push)
		`CHK("cur_update", 1, n_cu)
		`CHK("no_restart", 1, n_sp)
		`CHK("pos_kept", 32'h00001388, pos)
		// Band written while moving waits for the next move
		frame(16'h9902, {16'h0000, 16'h0064}, 8'h00, 1'b0);
		reply(16'h9902, 8'h02);
		`CHK("band_held", 32'h000007d0, band)
		motion_busy <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("band_later", 32'h00000064, band)
		// Spoiled check, then a wrong byte count: both dropped
		frame(16'h9906, {16'h0033}, 8'h00, 1'b1);
		u_pmnc_host_model.collect(GAP + 60);
		`CHK("bad_crc_quiet", 0, u_pmnc_host_model.rsp.size())
		frame(16'h9906, {16'h0033}, 8'h01, 1'b0);
		u_pmnc_host_model.collect(GAP + 60);
		`CHK("bad_cnt_quiet", 0, u_pmnc_host_model.rsp.size())
		`CHK("accel_kept", 16'h001e, acc)
		`CHK("frame_errors", 2, n_fe)
		// Partial block with push flag must not start a push
		frame(16'h9904, {16'h0000, 16'h1388, 16'h001e, 16'h0000, 16'h0006}, 8'h00, 1'b0);
		reply(16'h9904, 8'h05);
		`CHK("speed_new", 32'h00001388, spd)
		`CHK("partial_no_push", 1, n_sp)
		`CHK("idle_no_update", 1, n_cu)
		// Broadcast full block applies silently; bit2 clear still selects push
		dst = 8'h00;
		frame(16'h9900, {16'h0000, 16'h0fa0, 16'h0000, 16'h0064, 16'h0000, 16'h2710,
			16'h001e, 16'h007f, 16'h0002}, 8'h00, 1'b0);
		u_pmnc_host_model.collect(GAP + 60);
		`CHK("bcast_quiet", 0, u_pmnc_host_model.rsp.size())
		`CHK("bcast_pos", 32'h00000fa0, pos)
		`CHK("bcast_push", 2, n_sp)
		// A frame for another station is ignored and raises no error
		dst = 8'h02;
		frame(16'h9906, {16'h0033}, 8'h00, 1'b0);
		u_pmnc_host_model.collect(GAP + 60);
		`CHK("other_quiet", 0, u_pmnc_host_model.rsp.size())
		`CHK("other_accel", 16'h001e, acc)
		`CHK("other_no_err", 2, n_fe)
		summarize();
	end
endmodule
